/* verilog/smc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl
  import smc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // DMA master request
  input  wire logic        dma_req_i,
  input  wire logic [31:0] dma_addr_i,
  input  wire logic [1:0]  dma_size_i,
  input  wire logic [1:0]  dma_kind_i,
  // Processor master request
  input  wire logic        cpu_req_i,
  input  wire logic [31:0] cpu_addr_i,
  input  wire logic [1:0]  cpu_size_i,
  input  wire logic [1:0]  cpu_kind_i,
  // Control and status
  input  wire logic        remap_toggle_bit_i,
  input  wire logic        status_read_i,
  output logic             dma_gnt_o,
  output logic             cpu_gnt_o,
  output logic             done_o,
  output logic             abort_o,
  output logic [1:0]       tgt_o,
  output logic [31:0]      tgt_addr_o,
  output logic [1:0]       tgt_size_o,
  output logic             tgt_write_o,
  output logic             remap_o,
  output logic [31:0]      abort_status_register_o,
  output logic [31:0]      abort_address_register_o
);

  smc_arb_t    state_reg;
  smc_arb_t    state_next;
  logic        remap_reg;
  logic [31:0] cur_addr;
  logic [1:0]  cur_size;
  logic [1:0]  cur_kind;
  logic        cur_cpu;
  logic [1:0]  dec_tgt;
  logic [31:0] dec_addr;
  logic        dec_undef;
  logic        dec_misal;
  logic        dec_abort;
  logic        undefined_address_flag;
  logic        misaligned_address_flag;
  logic [1:0]  abort_size_field;
  logic [1:0]  abort_type_field;
  logic        dma_last_abort_flag;
  logic        cpu_last_abort_flag;
  logic        dma_sticky_abort_flag;
  logic        cpu_sticky_abort_flag;
  logic [31:0] abort_addr_reg;

  // Arbiter: a transfer takes one grant cycle, then the bus returns to idle
  always_comb begin
    state_next = SMC_ST_IDLE;
    case (state_reg)
      SMC_ST_IDLE: begin
        if (dma_req_i) state_next = SMC_ST_DMA;
        else if (cpu_req_i) state_next = SMC_ST_CPU;
      end
      SMC_ST_DMA: state_next = SMC_ST_IDLE;
      SMC_ST_CPU: state_next = SMC_ST_IDLE;
      default: state_next = SMC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) state_reg <= SMC_ST_IDLE;
    else state_reg <= state_next;
  end

  // Request chosen for decode, latched at grant time
  logic [31:0] lat_addr_reg;
  logic [1:0]  lat_size_reg;
  logic [1:0]  lat_kind_reg;
  logic        lat_cpu_reg;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_addr_reg <= SMC_ZERO32;
      lat_size_reg <= SMC_SZ_BYTE;
      lat_kind_reg <= SMC_TY_READ;
      lat_cpu_reg  <= 1'b0;
    end else if (state_reg == SMC_ST_IDLE) begin
      if (dma_req_i) begin
        lat_addr_reg <= dma_addr_i;
        lat_size_reg <= dma_size_i;
        lat_kind_reg <= dma_kind_i;
        lat_cpu_reg  <= 1'b0;
      end else if (cpu_req_i) begin
        lat_addr_reg <= cpu_addr_i;
        lat_size_reg <= cpu_size_i;
        lat_kind_reg <= cpu_kind_i;
        lat_cpu_reg  <= 1'b1;
      end
    end
  end

  assign cur_addr = lat_addr_reg;
  assign cur_size = lat_size_reg;
  assign cur_kind = lat_kind_reg;
  assign cur_cpu  = lat_cpu_reg;

  smc_decode u_decode (
    .addr_i       (cur_addr),
    .size_i       (cur_size),
    .kind_i       (cur_kind),
    .is_cpu_i     (cur_cpu),
    .remap_i      (remap_reg),
    .tgt_o        (dec_tgt),
    .local_addr_o (dec_addr),
    .undef_o      (dec_undef),
    .misal_o      (dec_misal)
  );

  assign dec_abort = (state_reg != SMC_ST_IDLE) && (dec_undef || dec_misal);

  // Remap toggle on a written one, zero has no effect
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) remap_reg <= 1'b0;
    else if (remap_toggle_bit_i) remap_reg <= ~remap_reg;
  end

  // Bus outputs, registered; aborted accesses are cancelled toward targets
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dma_gnt_o   <= 1'b0;
      cpu_gnt_o   <= 1'b0;
      done_o      <= 1'b0;
      abort_o     <= 1'b0;
      tgt_o       <= SMC_TGT_NONE;
      tgt_addr_o  <= SMC_ZERO32;
      tgt_size_o  <= SMC_SZ_BYTE;
      tgt_write_o <= 1'b0;
    end else begin
      dma_gnt_o   <= (state_next == SMC_ST_DMA);
      cpu_gnt_o   <= (state_next == SMC_ST_CPU);
      done_o      <= (state_reg != SMC_ST_IDLE);
      abort_o     <= dec_abort;
      tgt_o       <= dec_abort ? SMC_TGT_NONE : (state_reg != SMC_ST_IDLE ? dec_tgt
                                                  : SMC_TGT_NONE);
      tgt_addr_o  <= dec_addr;
      tgt_size_o  <= cur_size;
      tgt_write_o <= (state_reg != SMC_ST_IDLE) && !dec_abort && (cur_kind == SMC_TY_WRITE);
    end
  end

  // Abort detail capture
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      abort_addr_reg          <= SMC_ZERO32;
      undefined_address_flag  <= 1'b0;
      misaligned_address_flag <= 1'b0;
      abort_size_field        <= SMC_SZ_BYTE;
      abort_type_field        <= SMC_TY_READ;
      dma_last_abort_flag     <= 1'b0;
      cpu_last_abort_flag     <= 1'b0;
    end else if (dec_abort) begin
      abort_addr_reg          <= cur_addr;
      undefined_address_flag  <= dec_undef;
      misaligned_address_flag <= dec_misal;
      abort_size_field        <= cur_size;
      abort_type_field        <= cur_kind;
      dma_last_abort_flag     <= !cur_cpu;
      cpu_last_abort_flag     <= cur_cpu;
    end
  end

  // Sticky flags; a new abort wins over the read clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dma_sticky_abort_flag <= 1'b0;
      cpu_sticky_abort_flag <= 1'b0;
    end else begin
      if (dec_abort && !cur_cpu) dma_sticky_abort_flag <= 1'b1;
      else if (status_read_i) dma_sticky_abort_flag <= 1'b0;
      if (dec_abort && cur_cpu) cpu_sticky_abort_flag <= 1'b1;
      else if (status_read_i) cpu_sticky_abort_flag <= 1'b0;
    end
  end

  // Status words assembled from flops
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      abort_status_register_o  <= SMC_ZERO32;
      abort_address_register_o <= SMC_ZERO32;
      remap_o                  <= 1'b0;
    end else begin
      abort_status_register_o <= SMC_ZERO32;
      abort_status_register_o[SMC_ASR_UND]  <= undefined_address_flag;
      abort_status_register_o[SMC_ASR_MIS]  <= misaligned_address_flag;
      abort_status_register_o[SMC_ASR_SZ+:2] <= abort_size_field;
      abort_status_register_o[SMC_ASR_TY+:2] <= abort_type_field;
      abort_status_register_o[SMC_ASR_M0]   <= dma_last_abort_flag;
      abort_status_register_o[SMC_ASR_M1]   <= cpu_last_abort_flag;
      abort_status_register_o[SMC_ASR_SV0]  <= dma_sticky_abort_flag;
      abort_status_register_o[SMC_ASR_SV1]  <= cpu_sticky_abort_flag;
      abort_address_register_o <= abort_addr_reg;
      remap_o                  <= remap_reg;
    end
  end

  // Checks
  property p_dma_first;
    @(posedge mclk_i) disable iff (rst_i)
    (state_reg == SMC_ST_IDLE && dma_req_i) |=> state_reg == SMC_ST_DMA;
  endproperty
  a_dma_first: assert property (p_dma_first) else $error("dma not preferred");

  property p_undef_region;
    @(posedge mclk_i) disable iff (rst_i)
    (state_reg != SMC_ST_IDLE && cur_addr[SMC_REGION_HI:SMC_REGION_LO] != SMC_REGION_MEM
     && cur_addr[SMC_REGION_HI:SMC_REGION_LO] != SMC_REGION_PER) |=> abort_o;
  endproperty
  a_undef_region: assert property (p_undef_region) else $error("undefined not aborted");

  property p_hole_ok;
    @(posedge mclk_i) disable iff (rst_i)
    (state_reg != SMC_ST_IDLE && !dec_misal
     && cur_addr[SMC_REGION_HI:SMC_AREA_LO] == {SMC_REGION_MEM, SMC_AREA_HOLE}) |=> !abort_o;
  endproperty
  a_hole_ok: assert property (p_hole_ok) else $error("hole area aborted");

  property p_toggle;
    @(posedge mclk_i) disable iff (rst_i)
    remap_toggle_bit_i |=> remap_reg != $past(remap_reg);
  endproperty
  a_toggle: assert property (p_toggle) else $error("remap not toggled");

  property p_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !remap_toggle_bit_i |=> $stable(remap_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("remap changed");

  property p_addr_cap;
    @(posedge mclk_i) disable iff (rst_i)
    dec_abort |=> ##1 abort_address_register_o == $past(cur_addr, 2);
  endproperty
  a_addr_cap: assert property (p_addr_cap) else $error("abort address lost");

  property p_src;
    @(posedge mclk_i) disable iff (rst_i)
    dec_abort |=> ##1 abort_status_register_o[SMC_ASR_M1] == $past(cur_cpu, 2)
                  && abort_status_register_o[SMC_ASR_M0] != $past(cur_cpu, 2);
  endproperty
  a_src: assert property (p_src) else $error("abort source wrong");

  property p_fetch;
    @(posedge mclk_i) disable iff (rst_i)
    (cur_cpu && cur_kind == SMC_TY_FETCH) |-> !dec_misal;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch flagged misaligned");

  property p_one_cycle;
    @(posedge mclk_i) disable iff (rst_i)
    state_reg != SMC_ST_IDLE |=> state_reg == SMC_ST_IDLE;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("grant changed midway");

  property p_abort_all;
    @(posedge mclk_i) disable iff (rst_i)
    dec_abort |=> abort_o && done_o;
  endproperty
  a_abort_all: assert property (p_abort_all) else $error("abort not sent");

  property p_cancel;
    @(posedge mclk_i) disable iff (rst_i)
    dec_abort |=> tgt_o == SMC_TGT_NONE && !tgt_write_o;
  endproperty
  a_cancel: assert property (p_cancel) else $error("aborted access reached target");

  property p_undef_area;
    @(posedge mclk_i) disable iff (rst_i)
    (state_reg != SMC_ST_IDLE && cur_addr[SMC_REGION_HI:SMC_REGION_LO] == SMC_REGION_MEM
     && cur_addr[SMC_AREA_HI:SMC_AREA_LO] > SMC_AREA_HOLE) |=> abort_o;
  endproperty
  a_undef_area: assert property (p_undef_area) else $error("undefined area not aborted");

  property p_periph;
    @(posedge mclk_i) disable iff (rst_i)
    (state_reg != SMC_ST_IDLE && cur_addr[SMC_REGION_HI:SMC_REGION_LO] == SMC_REGION_PER
     && !dec_misal) |=> tgt_o == SMC_TGT_PERIPH && tgt_addr_o == $past(cur_addr);
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral access misrouted");

  property p_boot_alias;
    @(posedge mclk_i) disable iff (rst_i)
    (state_reg != SMC_ST_IDLE && !dec_misal
     && cur_addr[SMC_REGION_HI:SMC_AREA_LO] == {SMC_REGION_MEM, SMC_AREA_BOOT})
    |=> tgt_o == ($past(remap_reg) ? SMC_TGT_SRAM : SMC_TGT_FLASH);
  endproperty
  a_boot_alias: assert property (p_boot_alias) else $error("boot area wrong memory");

  property p_flash_alias;
    @(posedge mclk_i) disable iff (rst_i)
    (state_reg != SMC_ST_IDLE && !dec_misal
     && cur_addr[SMC_REGION_HI:SMC_AREA_LO] == {SMC_REGION_MEM, SMC_AREA_FLASH})
    |=> tgt_o == SMC_TGT_FLASH && (tgt_addr_o >> SMC_FLASH_AW) == SMC_ZERO32
        && tgt_addr_o[SMC_FLASH_AW-1:0] == $past(cur_addr[SMC_FLASH_AW-1:0]);
  endproperty
  a_flash_alias: assert property (p_flash_alias) else $error("flash alias wrong");

  property p_causes;
    @(posedge mclk_i) disable iff (rst_i)
    dec_abort |=> undefined_address_flag == $past(dec_undef)
                  && misaligned_address_flag == $past(dec_misal);
  endproperty
  a_causes: assert property (p_causes) else $error("abort cause flags wrong");

  property p_size_type;
    @(posedge mclk_i) disable iff (rst_i)
    dec_abort |=> abort_size_field == $past(cur_size)
                  && abort_type_field == $past(cur_kind);
  endproperty
  a_size_type: assert property (p_size_type) else $error("abort size or type wrong");

  property p_sticky;
    @(posedge mclk_i) disable iff (rst_i)
    dec_abort |=> ($past(cur_cpu) ? cpu_sticky_abort_flag : dma_sticky_abort_flag);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag not set");

  c_dma_abort: cover property (@(posedge mclk_i) disable iff (rst_i) dec_abort && !cur_cpu);
  c_cpu_misal: cover property (@(posedge mclk_i) disable iff (rst_i) dec_misal && cur_cpu);
  c_remap_sram: cover property (@(posedge mclk_i) disable iff (rst_i)
                                remap_reg && dec_tgt == SMC_TGT_SRAM);
  c_hole_hit: cover property (@(posedge mclk_i) disable iff (rst_i) state_reg != SMC_ST_IDLE
                              && cur_addr[SMC_REGION_HI:SMC_AREA_LO] == {SMC_REGION_MEM, SMC_AREA_HOLE});

endmodule // smc_ctrl
`default_nettype wire

/* verilog/smc_pkg.sv */
package smc_pkg;

  // Access size and type encodings
  localparam logic [1:0] SMC_SZ_BYTE  = 2'h0;
  localparam logic [1:0] SMC_SZ_HALF  = 2'h1;
  localparam logic [1:0] SMC_SZ_WORD  = 2'h2;
  localparam logic [1:0] SMC_TY_READ  = 2'h0;
  localparam logic [1:0] SMC_TY_WRITE = 2'h1;
  localparam logic [1:0] SMC_TY_FETCH = 2'h2;

  // Address decode fields
  localparam int          SMC_REGION_HI = 31;
  localparam int          SMC_REGION_LO = 28;
  localparam int          SMC_AREA_HI   = 27;
  localparam int          SMC_AREA_LO   = 20;
  localparam logic [3:0]  SMC_REGION_MEM = 4'h0;
  localparam logic [3:0]  SMC_REGION_PER = 4'hf;
  localparam logic [7:0]  SMC_AREA_BOOT  = 8'h00;
  localparam logic [7:0]  SMC_AREA_FLASH = 8'h01;
  localparam logic [7:0]  SMC_AREA_SRAM  = 8'h02;
  localparam logic [7:0]  SMC_AREA_HOLE  = 8'h03;

  // Memory sizes as offset widths inside a 1 MB area
  localparam int          SMC_AREA_AW   = 20;
  localparam int          SMC_FLASH_AW  = 18;
  localparam int          SMC_SRAM_AW   = 16;

  // Target select codes
  localparam logic [1:0]  SMC_TGT_NONE  = 2'h0;
  localparam logic [1:0]  SMC_TGT_FLASH = 2'h1;
  localparam logic [1:0]  SMC_TGT_SRAM  = 2'h2;
  localparam logic [1:0]  SMC_TGT_PERIPH = 2'h3;

  // Abort status word layout
  localparam int          SMC_ASR_UND   = 0;
  localparam int          SMC_ASR_MIS   = 1;
  localparam int          SMC_ASR_SZ    = 8;
  localparam int          SMC_ASR_TY    = 10;
  localparam int          SMC_ASR_M0    = 16;
  localparam int          SMC_ASR_M1    = 17;
  localparam int          SMC_ASR_SV0   = 24;
  localparam int          SMC_ASR_SV1   = 25;
  localparam logic [31:0] SMC_ZERO32    = 32'h0000_0000;

  typedef enum logic [1:0] {
    SMC_ST_IDLE = 2'b00,
    SMC_ST_DMA  = 2'b01,
    SMC_ST_CPU  = 2'b10
  } smc_arb_t;

endpackage : smc_pkg

/* verilog/smc_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// Address decoder and misalignment check for one granted access
module smc_decode
  import smc_pkg::*;
(
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [1:0]  kind_i,
  input  wire logic        is_cpu_i,
  input  wire logic        remap_i,
  output logic [1:0]       tgt_o,
  output logic [31:0]      local_addr_o,
  output logic             undef_o,
  output logic             misal_o
);

  logic [3:0] region;
  logic [7:0] area;

  assign region = addr_i[SMC_REGION_HI:SMC_REGION_LO];
  assign area   = addr_i[SMC_AREA_HI:SMC_AREA_LO];

  // Region and area decode with aliasing of small memories
  always_comb begin
    tgt_o        = SMC_TGT_NONE;
    local_addr_o = SMC_ZERO32;
    undef_o      = 1'b0;
    if (region == SMC_REGION_PER) begin
      tgt_o        = SMC_TGT_PERIPH;
      local_addr_o = addr_i;
    end else if (region != SMC_REGION_MEM) begin
      undef_o = 1'b1;
    end else if (area == SMC_AREA_FLASH || (area == SMC_AREA_BOOT && !remap_i)) begin
      tgt_o        = SMC_TGT_FLASH;
      local_addr_o = {{(32-SMC_FLASH_AW){1'b0}}, addr_i[SMC_FLASH_AW-1:0]};
    end else if (area == SMC_AREA_SRAM || (area == SMC_AREA_BOOT && remap_i)) begin
      tgt_o        = SMC_TGT_SRAM;
      local_addr_o = {{(32-SMC_SRAM_AW){1'b0}}, addr_i[SMC_SRAM_AW-1:0]};
    end else if (area == SMC_AREA_HOLE) begin
      tgt_o = SMC_TGT_NONE;
    end else begin
      undef_o = 1'b1;
    end
  end

  // Alignment check, skipped for processor fetches
  always_comb begin
    misal_o = 1'b0;
    if (!(is_cpu_i && kind_i == SMC_TY_FETCH)) begin
      if (size_i == SMC_SZ_WORD) misal_o = |addr_i[1:0];
      else if (size_i == SMC_SZ_HALF) misal_o = addr_i[0];
    end
  end

endmodule // smc_decode
`default_nettype wire

/* tb/smc_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus master stand-in: raises a request, holds it until granted, then lets go
module smc_master_model (
  input  wire logic        clk_i,
  input  wire logic        gnt_i,
  input  wire logic        abort_i,  // Not acted on here: both masters ignore it
  output logic             req_o,
  output logic [31:0]      addr_o,
  output logic [1:0]       size_o,
  output logic [1:0]       kind_o
);
  // Idle lines at time zero
  initial begin
    req_o = 1'b0;
    addr_o = 32'h0000_0000;
    size_o = 2'h0;
    kind_o = 2'h0;
  end

  // One transfer; released lines show the inverse, not a stale copy
  task issue(input logic [31:0] a, input logic [1:0] s, input logic [1:0] k);
    int n;
    @(negedge clk_i);
    req_o = 1'b1;
    addr_o = a;
    size_o = s;
    kind_o = k;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (gnt_i !== 1'b1 && n < 50);
    @(negedge clk_i);
    req_o = 1'b0;
    addr_o = ~a;
    size_o = ~s;
    kind_o = ~k;
  endtask
endmodule // smc_master_model
`default_nettype wire

/* tb/system_bus_memory_controller_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module system_bus_memory_controller_tb;
  import smc_pkg::*;
  logic        mclk_i, rst_i, remap_toggle_bit_i, status_read_i;
  logic        dma_req_i, cpu_req_i, dma_gnt_o, cpu_gnt_o, done_o, abort_o;
  logic        remap_o, tgt_write_o, exp_remap;
  logic [31:0] dma_addr_i, cpu_addr_i, tgt_addr_o, asr_o, aar_o, exp_asr, exp_aar;
  logic [1:0]  dma_size_i, dma_kind_i, cpu_size_i, cpu_kind_i, tgt_o, tgt_size_o;
  int          mismatches, samples_checked;

  smc_ctrl dut (.mclk_i(mclk_i), .rst_i(rst_i), .dma_req_i(dma_req_i),
    .dma_addr_i(dma_addr_i), .dma_size_i(dma_size_i), .dma_kind_i(dma_kind_i),
    .cpu_req_i(cpu_req_i), .cpu_addr_i(cpu_addr_i), .cpu_size_i(cpu_size_i),
    .cpu_kind_i(cpu_kind_i), .remap_toggle_bit_i(remap_toggle_bit_i),
    .status_read_i(status_read_i), .dma_gnt_o(dma_gnt_o), .cpu_gnt_o(cpu_gnt_o),
    .done_o(done_o), .abort_o(abort_o), .tgt_o(tgt_o), .tgt_addr_o(tgt_addr_o),
    .tgt_size_o(tgt_size_o), .tgt_write_o(tgt_write_o), .remap_o(remap_o),
    .abort_status_register_o(asr_o), .abort_address_register_o(aar_o));
  smc_master_model u_dma (.clk_i(mclk_i), .gnt_i(dma_gnt_o), .abort_i(abort_o),
    .req_o(dma_req_i), .addr_o(dma_addr_i), .size_o(dma_size_i), .kind_o(dma_kind_i));
  smc_master_model u_cpu (.clk_i(mclk_i), .gnt_i(cpu_gnt_o), .abort_i(abort_o),
    .req_o(cpu_req_i), .addr_o(cpu_addr_i), .size_o(cpu_size_i), .kind_o(cpu_kind_i));

  // 125 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task conclude();
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pulse remap toggle (which=1) or status read (which=0) for n cycles
  task pulse(input bit which, input int n);
    @(negedge mclk_i);
    if (which) remap_toggle_bit_i = 1'b1;
    else status_read_i = 1'b1;
    repeat (n) @(negedge mclk_i);
    remap_toggle_bit_i = 1'b0;
    status_read_i = 1'b0;
    @(negedge mclk_i);
  endtask

  // One access from either master, with its outcome predicted here
  task run(input bit d, input logic [31:0] a, input logic [1:0] s, input logic [1:0] k);
    logic       und, mis;
    logic [1:0] tg;
    logic [7:0] ar;
    logic [31:0] ta;
    int         n;
    ar = a[27:20];
    und = (a[31:28] != SMC_REGION_MEM && a[31:28] != SMC_REGION_PER) ||
          (a[31:28] == SMC_REGION_MEM && ar > SMC_AREA_HOLE);
    mis = !(k == SMC_TY_FETCH && !d) &&
          ((s == SMC_SZ_WORD && a[1:0] != 2'h0) || (s == SMC_SZ_HALF && a[0]));
    tg = SMC_TGT_NONE;
    ta = a;
    if (a[31:28] == SMC_REGION_PER) tg = SMC_TGT_PERIPH;
    else if (a[31:28] == SMC_REGION_MEM) begin
      if (ar == SMC_AREA_FLASH || (ar == SMC_AREA_BOOT && !exp_remap)) begin
        tg = SMC_TGT_FLASH;
        ta = {14'h0000, a[17:0]};
      end else if (ar == SMC_AREA_SRAM || (ar == SMC_AREA_BOOT && exp_remap)) begin
        tg = SMC_TGT_SRAM;
        ta = {16'h0000, a[15:0]};
      end
    end
    if (und | mis) tg = SMC_TGT_NONE;
    if (d) u_dma.issue(a, s, k);
    else u_cpu.issue(a, s, k);
    n = 0;
    while (done_o !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    check(32'(done_o), 32'h0000_0001);
    check(32'(abort_o), 32'(und | mis));
    check(32'(tgt_o), 32'(tg));
    if (tg != SMC_TGT_NONE) check(tgt_addr_o, ta);
    check(32'(tgt_size_o), 32'(s));
    check(32'(tgt_write_o), 32'(k == SMC_TY_WRITE && !(und | mis)));
    if (und | mis) begin
      exp_asr[SMC_ASR_UND] = und;
      exp_asr[SMC_ASR_MIS] = mis;
      exp_asr[SMC_ASR_SZ +: 2] = s;
      exp_asr[SMC_ASR_TY +: 2] = k;
      exp_asr[SMC_ASR_M0] = d;
      exp_asr[SMC_ASR_M1] = !d;
      if (d) exp_asr[SMC_ASR_SV0] = 1'b1;
      else exp_asr[SMC_ASR_SV1] = 1'b1;
      exp_aar = a;
    end
    @(negedge mclk_i);
    check(asr_o, exp_asr);
    check(aar_o, exp_aar);
  endtask

  // Watchdog
  initial begin
    #100_000;
    mismatches++;
    conclude();
  end

  // Main sequence
  initial begin
    int i;
    mismatches = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    remap_toggle_bit_i = 1'b0;
    status_read_i = 1'b0;
    exp_remap = 1'b0;
    exp_asr = SMC_ZERO32;
    exp_aar = SMC_ZERO32;
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    check(32'(remap_o), 32'h0000_0000);
    check(asr_o, SMC_ZERO32);
    check(aar_o, SMC_ZERO32);
    run(0, 32'h0010_0004, SMC_SZ_WORD, SMC_TY_READ);
    run(0, 32'h0014_0008, SMC_SZ_WORD, SMC_TY_READ);
    run(1, 32'h0021_2344, SMC_SZ_WORD, SMC_TY_WRITE);
    run(0, 32'h0000_0010, SMC_SZ_WORD, SMC_TY_FETCH);
    run(1, 32'hf000_1000, SMC_SZ_WORD, SMC_TY_READ);
    run(0, 32'h0030_0000, SMC_SZ_WORD, SMC_TY_READ);
    run(0, 32'h0040_0000, SMC_SZ_BYTE, SMC_TY_WRITE);
    run(0, 32'h0ff0_0000, SMC_SZ_HALF, SMC_TY_FETCH);
    for (i = 1; i < 15; i++) run(i[0], {i[3:0], 28'h000_0000}, SMC_SZ_WORD, SMC_TY_READ);
    run(1, 32'h0020_0002, SMC_SZ_WORD, SMC_TY_WRITE);
    run(1, 32'h0020_0001, SMC_SZ_HALF, SMC_TY_READ);
    run(1, 32'h0020_0002, SMC_SZ_HALF, SMC_TY_READ);
    run(1, 32'h0020_0003, SMC_SZ_BYTE, SMC_TY_WRITE);
    run(0, 32'h0010_0002, SMC_SZ_WORD, SMC_TY_FETCH);
    run(0, 32'h0010_0001, SMC_SZ_WORD, SMC_TY_READ);
    run(0, 32'h1000_0003, SMC_SZ_WORD, SMC_TY_READ);
    pulse(0, 1);
    exp_asr[SMC_ASR_SV0] = 1'b0;
    exp_asr[SMC_ASR_SV1] = 1'b0;
    check(asr_o, exp_asr);
    pulse(1, 1);
    exp_remap = 1'b1;
    check(32'(remap_o), 32'(exp_remap));
    run(0, 32'h0000_1234, SMC_SZ_WORD, SMC_TY_READ);
    run(0, 32'h0010_1234, SMC_SZ_WORD, SMC_TY_READ);
    repeat (3) @(negedge mclk_i);
    check(32'(remap_o), 32'(exp_remap));
    pulse(1, 2);
    check(32'(remap_o), 32'(exp_remap));
    pulse(1, 1);
    exp_remap = 1'b0;
    check(32'(remap_o), 32'(exp_remap));
    run(1, 32'h0000_1234, SMC_SZ_WORD, SMC_TY_READ);
    fork
      u_dma.issue(32'h0020_0010, SMC_SZ_WORD, SMC_TY_READ);
      u_cpu.issue(32'h0010_0010, SMC_SZ_WORD, SMC_TY_READ);
      begin
        i = 0;
        do begin
          @(negedge mclk_i);
          i++;
        end while (dma_gnt_o !== 1'b1 && cpu_gnt_o !== 1'b1 && i < 20);
        check(32'(dma_gnt_o), 32'h0000_0001);
        check(32'(cpu_gnt_o), 32'h0000_0000);
      end
    join
    repeat (4) @(negedge mclk_i);
    conclude();
  end
endmodule // system_bus_memory_controller_tb
`default_nettype wire
